// File: src/dpt_core.sv
// Device-side power-down, termination latency and write-leveling logic
`timescale 1ns/1ps
`default_nettype none
`include "dpt_defs.svh"
module dpt_core
	import dpt_pkg::*;
#(
	parameter int MAX_WL   = 19,
	parameter int OP_CLKS  = 8,
	parameter int XP_FL_PS = `DPT_XP_FLOOR_PS
) (
	// Clock and reset
	input  wire logic     mclk,
	input  wire logic     reset_n,
	// Command pins, same clock as mclk
	input  wire logic     cke,
	input  wire dpt_cmd_t cmd,
	input  wire logic     odt_pin,
	// Pins from outside the clock domain
	input  wire logic     odt_async_pin,
	input  wire logic     dqs_pin,
	input  wire logic     ck_pin,
	// Mode register settings
	input  wire dpt_cfg_t cfg,
	// Command and power state
	output var  logic     cmd_taken,
	output var  dpt_cmd_t cmd_word,
	output var  logic     in_powerdown,
	output var  logic     op_busy,
	// Termination control
	output var  logic     rtt_on,
	output var  logic     rtt_wr_sel,
	// Leveling feedback pin
	output var  logic     lvl_dq,
	output var  logic     lvl_dq_oe
);
	// ==========================================================
	// Derived constants
	localparam int CLK_PS   = `DPT_CLK_PS;
	localparam int XP_CEIL  = (XP_FL_PS + CLK_PS - 1) / CLK_PS;
	localparam int XP_CYC   = (XP_CEIL > `DPT_XP_MIN_NCK) ? XP_CEIL : `DPT_XP_MIN_NCK;
	localparam int LVL_FLR  = `DPT_LVL_FB_MAX_PS / CLK_PS;
	localparam int LVL_CYC  = (LVL_FLR < 1) ? 1 : LVL_FLR;
	localparam int HOLD_CYC = `DPT_DECODE_HOLD_NCK;
	localparam int BURST    = `DPT_WR_BURST_NCK;

	// Elaboration checks
	if (MAX_WL < 3 || MAX_WL > 30) begin : g_chk_wl
		$error("MAX_WL out of range");
	end
	if (OP_CLKS < 2 || OP_CLKS > 255) begin : g_chk_op
		$error("OP_CLKS out of range");
	end

	// ==========================================================
	// Synchronised pins: async termination, strobe, clock level
	logic [2:0] pin_lvl;
	dpt_pin_sync #(.W(3)) u_sync (
		.mclk    (mclk),
		.reset_n (reset_n),
		.pin     ({ck_pin, dqs_pin, odt_async_pin}),
		.level   (pin_lvl)
	);
	wire odt_lvl = pin_lvl[0];
	wire dqs_lvl = pin_lvl[1];
	wire ck_lvl  = pin_lvl[2];

	// ==========================================================
	// Clock-enable state machine
	dpt_state_t state;
	dpt_state_t next_state;
	logic [3:0] cnt;

	// Decode stays open through the hold after clock enable falls
	wire decode_en = (state == DPT_ACTIVE) || (state == DPT_HOLD);
	wire cmd_sel   = decode_en && !cmd.cs_n;
	wire is_wr     = cmd_sel && cmd.ras_n && !cmd.cas_n && !cmd.we_n;
	// Activate, precharge and refresh start a row operation
	wire op_start  = cmd_sel && !cmd.ras_n && (cmd.cas_n || cmd.we_n);

	always_comb begin
		next_state = state;
		unique case (state)
			DPT_ACTIVE: if (!cke) next_state = DPT_HOLD;
			DPT_HOLD:   if (cnt == 4'(HOLD_CYC - 1)) next_state = DPT_PD;
			DPT_PD:     if (cke) next_state = DPT_EXIT;
			DPT_EXIT:   if (cnt == 4'(XP_CYC - 1)) next_state = DPT_ACTIVE;
		endcase
	end

	// State and step counter
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state <= DPT_ACTIVE;
			cnt   <= '0;
		end else begin
			state <= next_state;
			cnt   <= (next_state != state) ? 4'h0 : cnt + 4'h1;
		end
	end

	// Command capture and power state flag
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_taken    <= 1'b0;
			cmd_word     <= '1;
			in_powerdown <= 1'b0;
		end else begin
			cmd_taken    <= cmd_sel;
			cmd_word     <= cmd;
			in_powerdown <= (next_state != DPT_ACTIVE);
		end
	end

	// ==========================================================
	// Row operations run to completion whatever clock enable does
	logic [7:0] op_cnt;
	wire  [7:0] next_op_cnt = op_start ? 8'(OP_CLKS) :
	                          (op_cnt != 8'h00) ? op_cnt - 8'h01 : 8'h00;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			op_cnt  <= '0;
			op_busy <= 1'b0;
		end else begin
			op_cnt  <= next_op_cnt;
			op_busy <= (next_op_cnt != 8'h00);
		end
	end

	// ==========================================================
	// Termination latency lines; index 0 is this edge's sample
	logic [MAX_WL-1:0] odt_hist;
	logic [MAX_WL-1:0] wr_hist;
	logic [BURST-1:0]  wr_win;
	wire  [MAX_WL:0]   odt_line = {odt_hist, odt_pin};
	wire  [MAX_WL:0]   wr_line  = {wr_hist, is_wr};
	wire  [4:0]        wl       = 5'(cfg.cwl) + 5'(cfg.al);
	wire  [4:0]        lat      = wl - 5'(`DPT_ODT_LAT_OFFSET);
	// Frozen DLL leaves no clock reference, so in power-down (DPT_PD) the synced pin is followed
	wire async_mode  = cfg.dll_frozen && (state == DPT_PD);
	wire next_rtt_on = async_mode ? odt_lvl : odt_line[lat];
	// Write window opens write latency after the write, for one burst
	wire [BURST-1:0] next_wr_win = {wr_win[BURST-2:0], wr_line[wl]};
	wire next_wr_sel = next_rtt_on && !async_mode && (|next_wr_win);

	// Lines shift every edge; outputs change on the reference edge itself
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			odt_hist   <= '0;
			wr_hist    <= '0;
			wr_win     <= '0;
			rtt_on     <= 1'b0;
			rtt_wr_sel <= 1'b0;
		end else begin
			odt_hist   <= odt_line[MAX_WL-1:0];
			wr_hist    <= wr_line[MAX_WL-1:0];
			wr_win     <= next_wr_win;
			rtt_on     <= next_rtt_on;
			rtt_wr_sel <= next_wr_sel;
		end
	end

	// ==========================================================
	// Write leveling: sample clock level on each strobe rise
	logic dqs_prev;
	wire  lvl_rise = cfg.lvl_en && dqs_lvl && !dqs_prev;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			dqs_prev  <= 1'b0;
			lvl_dq    <= 1'b0;
			lvl_dq_oe <= 1'b0;
		end else begin
			dqs_prev  <= dqs_lvl;
			lvl_dq    <= lvl_rise ? ck_lvl : lvl_dq;
			lvl_dq_oe <= cfg.lvl_en;
		end
	end

	// ==========================================================
	// Assertion helpers: edges since the last pin change or write
	logic [4:0] rise_age;
	logic [4:0] fall_age;
	logic [4:0] wr_age;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rise_age <= '1;
			fall_age <= '1;
			wr_age   <= '1;
		end else begin
			rise_age <= (odt_pin && !odt_hist[0]) ? 5'h00 : rise_age + 5'(rise_age != 5'h1f);
			fall_age <= (!odt_pin && odt_hist[0]) ? 5'h00 : fall_age + 5'(fall_age != 5'h1f);
			wr_age   <= is_wr ? 5'h00 : wr_age + 5'(wr_age != 5'h1f);
		end
	end

	sequence s_decode_window;
		decode_en [*2] ##1 !decode_en;
	endsequence

	a_decode_hold: assert property (@(posedge mclk) disable iff (!reset_n)
		(state == DPT_ACTIVE && !cke) |=> s_decode_window)
		else $error("decode window after clock enable low is wrong");

	a_odt_on_lat: assert property (@(posedge mclk) disable iff (!reset_n)
		($rose(rtt_on) && !async_mode && !$past(async_mode) && $stable(cfg))
		|-> (rise_age == lat))
		else $error("termination on latency wrong");

	a_odt_off_lat: assert property (@(posedge mclk) disable iff (!reset_n)
		($fell(rtt_on) && !async_mode && !$past(async_mode) && $stable(cfg))
		|-> (fall_age == lat))
		else $error("termination off latency wrong");

	a_async_follow: assert property (@(posedge mclk) disable iff (!reset_n)
		(async_mode && $past(async_mode)) |-> (rtt_on == $past(odt_lvl)))
		else $error("async termination does not follow pin");

	a_off_both: assert property (@(posedge mclk) disable iff (!reset_n)
		!rtt_on |-> !rtt_wr_sel)
		else $error("write termination left on after turn-off");

	a_dyn_switch: assert property (@(posedge mclk) disable iff (!reset_n)
		($rose(rtt_wr_sel) && $stable(rtt_on) && $stable(cfg)) |-> (wr_age == wl))
		else $error("dynamic termination change at wrong edge");

	a_lvl_feedback: assert property (@(posedge mclk) disable iff (!reset_n)
		lvl_rise |-> ##LVL_CYC (lvl_dq == $past(ck_lvl, LVL_CYC)) && lvl_dq_oe)
		else $error("leveling feedback wrong");

	a_op_start: assert property (@(posedge mclk) disable iff (!reset_n)
		op_start |=> op_busy ##1 op_busy)
		else $error("row operation not tracked");

	a_op_done: assert property (@(posedge mclk) disable iff (!reset_n)
		(op_cnt == 8'h01 && !op_start) |=> !op_busy)
		else $error("row operation did not finish");
endmodule
`default_nettype wire

// File: src/dpt_defs.svh
// Timing counts and fixed figures of the power-down and termination block
`ifndef DPT_DEFS_SVH
`define DPT_DEFS_SVH

// ==========================================================
// Clock
`define DPT_CLK_PS          50000
// ==========================================================
// Power-down timing
`define DPT_DECODE_HOLD_NCK 2
`define DPT_XP_MIN_NCK      3
`define DPT_XP_FLOOR_PS     6000
// ==========================================================
// Termination timing
`define DPT_ODT_LAT_OFFSET  2
`define DPT_WR_BURST_NCK    4
// ==========================================================
// Write leveling
`define DPT_LVL_FB_MAX_PS   7500

`endif

// File: src/dpt_pkg.sv
// Types shared by the power-down and termination block
package dpt_pkg;

	// Command pins as sampled on the clock
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
	} dpt_cmd_t;

	// Latency and mode settings held by the mode registers
	typedef struct packed {
		logic [3:0] cwl;
		logic [3:0] al;
		logic       dll_frozen;
		logic       lvl_en;
	} dpt_cfg_t;

	// Clock-enable state machine
	typedef enum logic [1:0] {
		DPT_ACTIVE,
		DPT_HOLD,
		DPT_PD,
		DPT_EXIT
	} dpt_state_t;

endpackage

// File: src/dpt_pin_sync.sv
// Three-stage synchroniser; a level counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module dpt_pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         reset_n,
	// Pin side
	input  wire logic [W-1:0] pin,
	// Clean level
	output var  logic [W-1:0] level
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// Stage one feeds stage two only; level holds while stages disagree
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			s1    <= '0;
			s2    <= '0;
			s3    <= '0;
			level <= '0;
		end else begin
			s1    <= pin;
			s2    <= s1;
			s3    <= s2;
			level <= ((s2 ~^ s3) & s3) | ((s2 ^ s3) & level);
		end
	end
endmodule
`default_nettype wire

// File: tb/dpt_ctrl_model.sv
// Controller stand-in driving clock enable, commands and termination pin
`timescale 1ns/1ps
`default_nettype none
module dpt_ctrl_model
	import dpt_pkg::*;
(
	// Clock
	input  wire logic     mclk,
	// Pins toward the device
	output var  logic     cke,
	output var  dpt_cmd_t cmd,
	output var  logic     odt_pin
);
	// ==========================================================
	// Idle levels: clock enabled, deselect, termination off
	initial begin
		cke     = 1'b1;
		cmd     = 4'hf;
		odt_pin = 1'b0;
	end

	// One-cycle command, then deselect so nothing is decoded twice
	task automatic issue(input dpt_cmd_t c);
		@(posedge mclk) cmd <= c;
		@(posedge mclk) cmd <= 4'hf;
	endtask

	// Spacing before clock enable falls; caller passes the longest pending count
	task automatic pd_spacing(input int clks);
		repeat (clks) @(posedge mclk);
	endtask

	// Clock enable only; mclk is never stopped by this model
	task automatic set_cke(input logic v);
		@(posedge mclk) cke <= v;
	endtask

	// Termination control level, held until the next call
	task automatic set_odt(input logic v);
		@(posedge mclk) odt_pin <= v;
	endtask
endmodule
`default_nettype wire

// File: tb/dpt_core_bench.sv
// Self-checking bench for the power-down, termination and leveling core
`timescale 1ns/1ps
`default_nettype none
`include "dpt_defs.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module dpt_core_bench
	import dpt_pkg::*;
;
	logic     mclk;
	logic     reset_n;
	logic     cke;
	dpt_cmd_t cmd;
	logic     odt_pin;
	logic     odt_async_pin;
	logic     dqs_pin;
	logic     ck_pin;
	dpt_cfg_t cfg;
	logic     cmd_taken;
	dpt_cmd_t cmd_word;
	logic     in_powerdown;
	logic     op_busy;
	logic     rtt_on;
	logic     rtt_wr_sel;
	logic     lvl_dq;
	logic     lvl_dq_oe;
	int       checks = 0;
	int       fails = 0;

	// ==========================================================
	// Design and controller stand-in; short row-operation count
	dpt_core #(
		.OP_CLKS (4)
	) dpt_core_i (
		.mclk          (mclk),
		.reset_n       (reset_n),
		.cke           (cke),
		.cmd           (cmd),
		.odt_pin       (odt_pin),
		.odt_async_pin (odt_async_pin),
		.dqs_pin       (dqs_pin),
		.ck_pin        (ck_pin),
		.cfg           (cfg),
		.cmd_taken     (cmd_taken),
		.cmd_word      (cmd_word),
		.in_powerdown  (in_powerdown),
		.op_busy       (op_busy),
		.rtt_on        (rtt_on),
		.rtt_wr_sel    (rtt_wr_sel),
		.lvl_dq        (lvl_dq),
		.lvl_dq_oe     (lvl_dq_oe)
	);
	dpt_ctrl_model dpt_ctrl_model_i (
		.mclk    (mclk),
		.cke     (cke),
		.cmd     (cmd),
		.odt_pin (odt_pin)
	);

	// Controller-side figures; plain stand-ins for this bench
	localparam int RL_NCK  = 8;
	localparam int WR_PS   = 20000;
	localparam int MOD_NCK = 16;
	// Write recovery in clocks, rounded up
	localparam int WR_NCK  = (WR_PS + `DPT_CLK_PS - 1) / `DPT_CLK_PS;

	// 20 MHz clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// Sample just after the edge so registered outputs have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic end_of_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Bounded exit; edges counted from the edge that raises cke
	task automatic pd_exit();
		int n;
		n = 0;
		dpt_ctrl_model_i.set_cke(1'b1);
		#1;
		while (n < 8 && in_powerdown !== 1'b0) begin
			cyc(1);
			n++;
		end
		// A hang counts as a mismatch and ends the run
		if (n == 8) begin
			fails++;
			end_of_test();
		end else begin
			`CHK(n, 1 + `DPT_XP_MIN_NCK)
			cyc(3);
		end
	endtask

	task automatic wait_rtt(input logic v);
		int n;
		n = 0;
		while (n < 8 && rtt_on !== v) begin
			cyc(1);
			n++;
		end
		if (n == 8) begin
			fails++;
			end_of_test();
		end else begin
			`CHK(rtt_on, v)
		end
	endtask

	// ==========================================================
	// Scenarios
	// Row operations keep running into power-down
	task automatic t_row_ops();
		dpt_cmd_t ops [3] = '{4'h3, 4'h2, 4'h1};
		foreach (ops[i]) begin
			dpt_ctrl_model_i.issue(ops[i]);
			#1;
			`CHK(cmd_taken, 1'b1)
			`CHK(cmd_word, ops[i])
			dpt_ctrl_model_i.set_cke(1'b0);
			cyc(2);
			`CHK(op_busy, 1'b1)
			cyc(1);
			`CHK(op_busy, 1'b0)
			`CHK(in_powerdown, 1'b1)
			pd_exit();
		end
	endtask

	// Command right after cke low still decoded, later ones refused
	// Read first, then only no-ops while the decode hold lasts
	task automatic t_decode_hold();
		dpt_ctrl_model_i.issue(4'h5);
		#1;
		`CHK(cmd_word, 4'h5)
		dpt_ctrl_model_i.pd_spacing(RL_NCK + 4 + 1);
		dpt_ctrl_model_i.set_cke(1'b0);
		dpt_ctrl_model_i.issue(4'h7);
		#1;
		`CHK(cmd_taken, 1'b1)
		`CHK(cmd_word, 4'h7)
		cyc(2);
		dpt_ctrl_model_i.issue(4'h3);
		#1;
		`CHK(cmd_taken, 1'b0)
		pd_exit();
	endtask

	// Turn-on, write switch and turn-off at the latency edges
	task automatic t_odt(input logic [3:0] cwl, input logic [3:0] al);
		int wl;
		wl = cwl + al;
		@(posedge mclk);
		cfg <= '{cwl, al, 1'b0, 1'b0};
		dpt_ctrl_model_i.set_odt(1'b1);
		cyc(wl - 2);
		`CHK(rtt_on, 1'b0)
		cyc(1);
		`CHK(rtt_on, 1'b1)
		dpt_ctrl_model_i.issue(4'h4);
		cyc(wl - 1);
		`CHK(rtt_wr_sel, 1'b0)
		cyc(1);
		`CHK(rtt_wr_sel, 1'b1)
		cyc(3);
		`CHK(rtt_wr_sel, 1'b1)
		cyc(1);
		`CHK(rtt_wr_sel, 1'b0)
		dpt_ctrl_model_i.set_odt(1'b0);
		cyc(wl - 2);
		`CHK(rtt_on, 1'b1)
		cyc(1);
		`CHK(rtt_on, 1'b0)
		// Write to power-down spacing, auto-precharge clock included
		dpt_ctrl_model_i.pd_spacing(wl + 4 + WR_NCK + 1);
	endtask

	// Frozen-DLL power-down: termination tracks the async pin
	task automatic t_async_odt();
		dpt_ctrl_model_i.issue(4'h0);
		cfg.dll_frozen <= 1'b1;
		dpt_ctrl_model_i.pd_spacing(MOD_NCK);
		dpt_ctrl_model_i.set_cke(1'b0);
		cyc(4);
		@(posedge mclk);
		odt_async_pin <= 1'b1;
		wait_rtt(1'b1);
		@(posedge mclk);
		odt_async_pin <= 1'b0;
		wait_rtt(1'b0);
		pd_exit();
		@(posedge mclk);
		cfg.dll_frozen <= 1'b0;
	endtask

	// Leveling feedback returns the sampled clock level
	task automatic t_level();
		dpt_ctrl_model_i.issue(4'h0);
		cfg.lvl_en <= 1'b1;
		cyc(2);
		`CHK(lvl_dq_oe, 1'b1)
		cyc(40);
		for (int i = 0; i < 2; i++) begin
			@(posedge mclk);
			ck_pin <= ~i[0];
			dqs_pin <= 1'b1;
			cyc(6);
			`CHK(lvl_dq, ~i[0])
			@(posedge mclk);
			dqs_pin <= 1'b0;
			cyc(5);
		end
		@(posedge mclk);
		cfg.lvl_en <= 1'b0;
		cyc(2);
		`CHK(lvl_dq_oe, 1'b0)
	endtask

	// Reset, then every scenario in turn
	initial begin
		reset_n = 1'b0;
		odt_async_pin = 1'b0;
		dqs_pin = 1'b0;
		ck_pin = 1'b0;
		cfg = '{4'h5, 4'h0, 1'b0, 1'b0};
		cyc(16);
		`CHK(cmd_word, 4'hf)
		@(posedge mclk);
		reset_n <= 1'b1;
		cyc(4);
		t_row_ops();
		t_decode_hold();
		t_odt(4'h5, 4'h0);
		t_odt(4'h7, 4'h4);
		t_async_odt();
		t_level();
		end_of_test();
	end
endmodule
`default_nettype wire
